// [common/lpd_pkg.sv]
// Package: register map, field positions, reset values and timing counts of the LED dimmer
//
// How it works
// - primary_mode[7:5] read-only auto-increment bits, reset zero
// - primary_mode[4] low power, stops oscillator, resets one
// - oscillator needs 500 us after leaving low power
// - asleep: no LED control, register writes refused except to primary_mode
// - primary_mode[0] enables broadcast address, resets one
// - secondary_mode[5] picks dimming or blinking; reserved zero
// - secondary_mode[3] updates outputs on STOP or ACK
// - update point applies to registers 02h to 0Bh
// - watchdog enable and four selectable periods
// - eight 8-bit brightness registers drive 97 kHz PWM
// - duty is value over 256, linear
// - brightness acts only on states 10 and 11
// - dimming mode superimposes 190 Hz group PWM
// - group duty over 256, resets FFh, state 11
// - blinking uses period and duty registers
// - blink period is (value plus one) over 24 s
// - state field: off, on, PWM, PWM plus group
// - auto-increment advances pointer with option wrap
package lpd_pkg;
  // Clock rate
  localparam int CLK_HZ         = 100_000_000;
  // Register offsets
  localparam logic [4:0] REG_PRI_MODE  = 5'h00;
  localparam logic [4:0] REG_SEC_MODE  = 5'h01;
  localparam logic [4:0] REG_BRI_FIRST = 5'h02;
  localparam logic [4:0] REG_BRI_LAST  = 5'h09;
  localparam logic [4:0] REG_GRP_DUTY  = 5'h0a;
  localparam logic [4:0] REG_GRP_PER   = 5'h0b;
  localparam logic [4:0] REG_LAST      = 5'h11;
  // Field positions of primary_mode
  localparam int PRI_AI_LSB   = 5;
  localparam int PRI_SLEEP    = 4;
  localparam int PRI_SUBCALL_FIRST_ENABLE     = 3;
  localparam int PRI_SUBCALL_THIRD_ENABLE     = 1;
  localparam int PRI_BROADCAST_ADDRESS_ENABLE  = 0;
  // Field positions of secondary_mode
  localparam int SEC_GROUP_FUNCTION_SELECT   = 5;
  localparam int SEC_OCH      = 3;
  localparam int SEC_WDT_ON   = 2;
  // Reset values
  localparam logic [4:0] PRI_RST        = 5'h11;
  localparam logic [7:0] GRP_DUTY_RST   = 8'hff;
  localparam logic [1:0] WDT_PER_RST    = 2'h3;
  // Auto-increment option codes
  localparam logic [2:0] AI_ALL   = 3'h4;
  localparam logic [2:0] AI_BRI   = 3'h5;
  localparam logic [2:0] AI_GLOB  = 3'h6;
  localparam logic [2:0] AI_BOTH  = 3'h7;
  // Output state field codes
  localparam logic [1:0] ST_OFF   = 2'h0;
  localparam logic [1:0] ST_ON    = 2'h1;
  localparam logic [1:0] ST_IND   = 2'h2;
  localparam logic [1:0] ST_GRP   = 2'h3;
  // Times in their own units
  localparam int OSC_START_US   = 500;
  localparam int IND_FREQ_HZ    = 97_000;
  localparam int GRP_FREQ_HZ    = 190;
  localparam int BLINK_DIV      = 24;
  localparam int PWM_STEPS      = 256;
  localparam int WDT_UNIT_MS    = 1;
  // Cycle counts derived from the clock
  localparam int OSC_START_CYC  = OSC_START_US * (CLK_HZ / 1_000_000);
  localparam int IND_STEP_CYC   = CLK_HZ / (IND_FREQ_HZ * PWM_STEPS);
  localparam int GRP_STEP_CYC   = CLK_HZ / (GRP_FREQ_HZ * PWM_STEPS);
  localparam int BLINK_STEP_CYC = CLK_HZ / (BLINK_DIV * PWM_STEPS);
  localparam int WDT_UNIT_CYC   = WDT_UNIT_MS * (CLK_HZ / 1000);
  // Watchdog periods in ms units
  localparam logic [5:0] WDT_MS_0 = 6'd5;
  localparam logic [5:0] WDT_MS_1 = 6'd15;
  localparam logic [5:0] WDT_MS_2 = 6'd25;
  localparam logic [5:0] WDT_MS_3 = 6'd35;
  // Counter width for long prescalers
  localparam int CNT_W = 20;

  // Whole state of the core
  typedef struct packed {
    logic [4:0]      pri;       // sleep, subcall_first_enable..3, broadcast_address_enable
    logic            group_function_select;    // group function select
    logic            output_update_point;       // output update point
    logic            wdt_on;    // watchdog on
    logic [1:0]      wdt_per;   // watchdog interval
    logic [2:0]      ai;        // auto-increment mode
    logic [4:0]      ptr;       // register pointer
    logic [7:0][7:0] bri_stg;   // staged brightness
    logic [7:0]      gdu_stg;   // staged group duty
    logic [7:0]      gpr_stg;   // staged blink period
    logic [7:0][7:0] bri;       // live brightness
    logic [7:0]      gdu;       // live group duty
    logic [7:0]      gpr;       // live blink period
    logic [CNT_W-1:0] osc_cnt;  // oscillator start timer
    logic            osc_run;   // oscillator usable
    logic [CNT_W-1:0] ind_pre;  // individual step prescaler
    logic [7:0]      ind_ph;    // individual PWM phase
    logic [CNT_W-1:0] grp_pre;  // group step prescaler
    logic [7:0]      grp_ph;    // group PWM phase
    logic [CNT_W-1:0] blk_pre;  // blink step prescaler
    logic [7:0]      blk_sub;   // blink step divider
    logic [7:0]      blk_ph;    // blink phase
    logic [CNT_W-1:0] wdt_pre;  // watchdog ms prescaler
    logic [5:0]      wdt_ms;    // watchdog ms count
    logic            wdt_exp;   // watchdog expired flag
    logic [7:0]      led_on;    // LED drive levels
    logic [7:0]      rd_data;   // read data at pointer
  } lpd_state_type;
endpackage

// [core/lpd_core.sv]
// Core: mode registers, brightness and group PWM, blinking and watchdog of the LED dimmer
`timescale 1ns/1ps
`default_nettype none
module lpd_core
  import lpd_pkg::*;
#(
  parameter int OSC_START = OSC_START_CYC,   // oscillator start delay, cycles
  parameter int GRP_STEP  = BLINK_STEP_CYC,  // unused; defaults to the blink step, the group phase uses GRP_STEP_CYC
  parameter int BLK_STEP  = BLINK_STEP_CYC,  // blink step, cycles
  parameter int WDT_UNIT  = WDT_UNIT_CYC     // watchdog ms unit, cycles
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Control byte from the bus front end
  input  wire logic        ctrl_wr_in,
  input  wire logic [7:0]  ctrl_data_in,
  // Data byte strobes from the bus front end
  input  wire logic        data_wr_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        data_rd_in,
  // Bus events
  input  wire logic        ack_in,
  input  wire logic        stop_in,
  // Output state fields, two bits per LED
  input  wire logic [15:0] led_state_in,
  // Read path and pointer
  output logic [7:0]       rd_data_out,
  output logic [4:0]       reg_ptr_out,
  // Address enables for the front end
  output logic [2:0]       subcall_en_out,
  output logic             broadcast_address_enable_out,
  // Status
  output logic             osc_running_out,
  output logic             wdt_expired_out,
  // LED drive, high means sink current
  output logic [7:0]       led_on_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  lpd_state_type st_ff;       // current state
  lpd_state_type nxt_st;      // next state

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pointer advance after each data byte
  function automatic logic [4:0] next_ptr(input logic [4:0] p, input logic [2:0] ai);
    logic [4:0] n;
    n = p;
    case (ai)
      AI_ALL:  n = (p == REG_LAST) ? REG_PRI_MODE : p + 5'h01;
      AI_BRI:  n = (p == REG_BRI_LAST) ? REG_BRI_FIRST : p + 5'h01;
      AI_GLOB: n = (p == REG_GRP_PER) ? REG_GRP_DUTY : p + 5'h01;
      AI_BOTH: n = (p == REG_GRP_PER) ? REG_BRI_FIRST : p + 5'h01;
      default: n = p;
    endcase
    return n;
  endfunction

  // Register read mux; reserved bits read zero
  function automatic logic [7:0] read_reg(input lpd_state_type s);
    logic [7:0] d;
    d = 8'h00;
    if (s.ptr == REG_PRI_MODE) begin
      d = {s.ai, s.pri};
    end else if (s.ptr == REG_SEC_MODE) begin
      d = {2'h0, s.group_function_select, 1'b0, s.output_update_point, s.wdt_on, s.wdt_per};
    end else if (s.ptr >= REG_BRI_FIRST && s.ptr <= REG_BRI_LAST) begin
      d = s.bri_stg[3'(s.ptr - REG_BRI_FIRST)];
    end else if (s.ptr == REG_GRP_DUTY) begin
      d = s.gdu_stg;
    end else if (s.ptr == REG_GRP_PER) begin
      d = s.gpr_stg;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic       asleep;     // low-power bit set
    logic       bus_act;    // any control, data write or data read strobe
    logic       grp_on;     // group signal on phase
    logic       ind_on;     // individual signal on phase
    logic [1:0] fld;        // one output state field
    logic [5:0] wdt_lim;    // selected watchdog period
    asleep  = 1'b0;
    bus_act = 1'b0;
    grp_on  = 1'b0;
    ind_on  = 1'b0;
    fld     = ST_OFF;
    wdt_lim = WDT_MS_3;
    nxt_st  = st_ff;
    asleep  = st_ff.pri[PRI_SLEEP];
    bus_act = ctrl_wr_in | data_wr_in | data_rd_in;

    // Control byte loads pointer and auto-increment mode
    if (ctrl_wr_in) begin
      nxt_st.ptr = ctrl_data_in[4:0];
      nxt_st.ai  = ctrl_data_in[7:5];
    end else if (data_wr_in || data_rd_in) begin
      nxt_st.ptr = next_ptr(st_ff.ptr, st_ff.ai);
    end

    // Data writes; while asleep only primary_mode is writable so software can wake
    if (data_wr_in && (!asleep || st_ff.ptr == REG_PRI_MODE)) begin
      if (st_ff.ptr == REG_PRI_MODE) begin
        nxt_st.pri = data_in[4:0];
      end else if (st_ff.ptr == REG_SEC_MODE) begin
        nxt_st.group_function_select  = data_in[SEC_GROUP_FUNCTION_SELECT];
        nxt_st.output_update_point     = data_in[SEC_OCH];
        nxt_st.wdt_on  = data_in[SEC_WDT_ON];
        nxt_st.wdt_per = data_in[1:0];
      end else if (st_ff.ptr >= REG_BRI_FIRST && st_ff.ptr <= REG_BRI_LAST) begin
        nxt_st.bri_stg[3'(st_ff.ptr - REG_BRI_FIRST)] = data_in;
      end else if (st_ff.ptr == REG_GRP_DUTY) begin
        nxt_st.gdu_stg = data_in;
      end else if (st_ff.ptr == REG_GRP_PER) begin
        nxt_st.gpr_stg = data_in;
      end
    end

    // Staged values reach the outputs at STOP, or at every ACK when selected
    if (stop_in || (st_ff.output_update_point && ack_in)) begin
      nxt_st.bri = nxt_st.bri_stg;
      nxt_st.gdu = nxt_st.gdu_stg;
      nxt_st.gpr = nxt_st.gpr_stg;
    end

    // Oscillator start timer; outputs are held off until it has run out
    if (asleep) begin
      nxt_st.osc_cnt = '0;
      nxt_st.osc_run = 1'b0;
    end else if (!st_ff.osc_run) begin
      if (st_ff.osc_cnt == CNT_W'(OSC_START - 1)) begin
        nxt_st.osc_run = 1'b1;
      end else begin
        nxt_st.osc_cnt = st_ff.osc_cnt + 1'b1;
      end
    end

    // Time bases run only with the oscillator
    if (st_ff.osc_run) begin
      // Individual 97 kHz PWM phase
      if (st_ff.ind_pre == CNT_W'(IND_STEP_CYC - 1)) begin
        nxt_st.ind_pre = '0;
        nxt_st.ind_ph  = st_ff.ind_ph + 8'h01;
      end else begin
        nxt_st.ind_pre = st_ff.ind_pre + 1'b1;
      end
      // Group 190 Hz dimming phase
      if (st_ff.grp_pre == CNT_W'(GRP_STEP_CYC - 1)) begin
        nxt_st.grp_pre = '0;
        nxt_st.grp_ph  = st_ff.grp_ph + 8'h01;
      end else begin
        nxt_st.grp_pre = st_ff.grp_pre + 1'b1;
      end
      // Blink phase: 256 steps each of (period + 1) base ticks
      if (st_ff.blk_pre == CNT_W'(BLK_STEP - 1)) begin
        nxt_st.blk_pre = '0;
        if (st_ff.blk_sub >= st_ff.gpr) begin
          nxt_st.blk_sub = 8'h00;
          nxt_st.blk_ph  = st_ff.blk_ph + 8'h01;
        end else begin
          nxt_st.blk_sub = st_ff.blk_sub + 8'h01;
        end
      end else begin
        nxt_st.blk_pre = st_ff.blk_pre + 1'b1;
      end
    end

    // Watchdog: bus silence longer than the selected period raises the flag
    case (st_ff.wdt_per)
      2'h0:    wdt_lim = WDT_MS_0;
      2'h1:    wdt_lim = WDT_MS_1;
      2'h2:    wdt_lim = WDT_MS_2;
      default: wdt_lim = WDT_MS_3;
    endcase
    if (!st_ff.wdt_on || bus_act) begin
      nxt_st.wdt_pre = '0;
      nxt_st.wdt_ms  = 6'h00;
    end else if (st_ff.wdt_pre == CNT_W'(WDT_UNIT - 1)) begin
      nxt_st.wdt_pre = '0;
      nxt_st.wdt_ms  = (st_ff.wdt_ms == wdt_lim) ? 6'h00 : st_ff.wdt_ms + 6'h01;
    end else begin
      nxt_st.wdt_pre = st_ff.wdt_pre + 1'b1;
    end
    // Expiry sets, any bus access clears; a bus access in the expiry cycle blocks the set
    if (bus_act) begin
      nxt_st.wdt_exp = 1'b0;
    end
    if (st_ff.wdt_on && !bus_act && st_ff.wdt_ms == wdt_lim
        && st_ff.wdt_pre == CNT_W'(WDT_UNIT - 1)) begin
      nxt_st.wdt_exp = 1'b1;
    end

    // Group signal: dimming PWM or blink pattern, same duty register
    if (st_ff.group_function_select) begin
      grp_on = st_ff.blk_ph < st_ff.gdu;
    end else begin
      grp_on = st_ff.grp_ph < st_ff.gdu;
    end

    // Per-output drive decision
    for (int i = 0; i < 8; i++) begin
      fld    = led_state_in[2*i +: 2];
      ind_on = st_ff.ind_ph < st_ff.bri[i];
      case (fld)
        ST_OFF:  nxt_st.led_on[i] = 1'b0;
        ST_ON:   nxt_st.led_on[i] = 1'b1;
        ST_IND:  nxt_st.led_on[i] = ind_on;
        ST_GRP:  nxt_st.led_on[i] = ind_on & grp_on;
        default: nxt_st.led_on[i] = 1'b0;
      endcase
      // No LED control without a running oscillator
      if (!st_ff.osc_run) begin
        nxt_st.led_on[i] = 1'b0;
      end
    end

    // Read data is taken from the next state, so it matches the pointer in the same cycle
    nxt_st.rd_data = read_reg(nxt_st);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff         <= '0;
      st_ff.pri     <= PRI_RST;        // asleep, broadcast enabled
      st_ff.wdt_per <= WDT_PER_RST;
      st_ff.gdu_stg <= GRP_DUTY_RST;
      st_ff.gdu     <= GRP_DUTY_RST;
      st_ff.rd_data <= {3'h0, PRI_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign rd_data_out                  = st_ff.rd_data;
  assign reg_ptr_out                  = st_ff.ptr;
  assign subcall_en_out               = st_ff.pri[PRI_SUBCALL_FIRST_ENABLE:PRI_SUBCALL_THIRD_ENABLE];
  assign broadcast_address_enable_out = st_ff.pri[PRI_BROADCAST_ADDRESS_ENABLE];
  assign osc_running_out              = st_ff.osc_run;
  assign wdt_expired_out              = st_ff.wdt_exp;
  assign led_on_out                   = st_ff.led_on;

endmodule
`default_nettype wire

// [test/led_pwm_dimming_blinking_test.sv]
// Testbench: registers, sleep, pointer and PWM duty of the LED dimmer core
`timescale 1ns/1ps
`default_nettype none
module led_pwm_dimming_blinking_test
  import lpd_pkg::*;
;
  localparam int PER = PWM_STEPS * IND_STEP_CYC; // One individual PWM period
  logic        clk_in, sys_rst_in, c_wr, d_wr, d_rd, ack, stop, osc, wdt, bc;
  logic [7:0]  c_dat, w_dat, rd, led, got, v;
  logic [15:0] st;
  logic [4:0]  ptr;
  logic [2:0]  sub;
  logic [7:0]  shadow [10];
  int          err_count, n_checks, i;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  lpd_core #(.OSC_START(20), .BLK_STEP(4), .WDT_UNIT(10)) u_dut (.clk_in, .sys_rst_in,
    .ctrl_wr_in(c_wr), .ctrl_data_in(c_dat), .data_wr_in(d_wr), .data_in(w_dat),
    .data_rd_in(d_rd), .ack_in(ack), .stop_in(stop), .led_state_in(st), .rd_data_out(rd),
    .reg_ptr_out(ptr), .subcall_en_out(sub), .broadcast_address_enable_out(bc),
    .osc_running_out(osc), .wdt_expired_out(wdt), .led_on_out(led));
  lpd_bus_master u_bfm (.clk_in, .rd_data_in(rd), .ctrl_wr_out(c_wr), .data_wr_out(d_wr),
    .data_rd_out(d_rd), .ack_out(ack), .stop_out(stop), .ctrl_data_out(c_dat), .data_out(w_dat));
  // Compare tasks: register bytes and PWM on-counts
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reset image; unmapped tail reads as zero
  function automatic logic [7:0] rst_val(input int a);
    case (a)
      0: return {AI_ALL, PRI_RST};  // Upper bits mirror the full-map control byte
      1: return {6'h00, WDT_PER_RST};
      10: return GRP_DUTY_RST;
      default: return 8'h00;
    endcase
  endfunction
  // Fresh random output states; group state kept out of the on-count model
  task automatic rnd_st;
    for (int k = 0; k < 8; k++) st[2*k+:2] = 2'($urandom % 3);
  endtask
  // High cycles per period for a state field and brightness
  function automatic logic [15:0] exp_cnt(input logic [1:0] s, input logic [7:0] b);
    if (s == ST_OFF) return 16'h0000;
    if (s == ST_ON) return 16'(PER);
    return 16'(b) * 16'(IND_STEP_CYC);
  endfunction
  // Count LEDs 0..4 over one period; LEDs 0..4 carry live values
  task automatic measure(input logic [7:0] b [5], input string name);
    logic [15:0] cnt [5];
    cnt = '{default: 16'h0000};
    repeat (4) @(negedge clk_in);
    repeat (PER) begin
      @(negedge clk_in);
      for (int k = 0; k < 5; k++) cnt[k] += 16'(led[k]);
    end
    for (int k = 0; k < 5; k++) chk16(cnt[k], exp_cnt(st[2*k+:2], b[k]));
    $display("test %s done", name);
  endtask
  initial begin
    err_count = 0;
    n_checks = 0;
    st = 16'h021a;
    sys_rst_in = 1'b1;
    v = $urandom(32'ha52fd8f9);
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
    u_bfm.put_ctrl(8'h80);
    for (int a = 0; a < 18; a++) begin
      u_bfm.get_data(got);
      chk8(got, rst_val(a));
    end
    u_bfm.put_ctrl(8'h91);
    u_bfm.get_data(got);
    u_bfm.get_data(got);
    chk8(got, rst_val(0));
    $display("test reset_map done");
    u_bfm.put_ctrl(8'h02);
    u_bfm.put_data(8'h5c);
    u_bfm.put_stop;
    u_bfm.get_data(got);
    chk8(got, 8'h00);
    u_bfm.put_ctrl(8'h00);
    u_bfm.put_data(8'hef);
    for (i = 0; i < 100 && osc !== 1'b1; i++) @(negedge clk_in);
    if (i == 100) begin
      err_count++;
      end_of_test();
    end
    chk8({7'h00, i >= 15}, 8'h01);
    u_bfm.get_data(got);
    chk8(got, 8'h0f);
    chk8({5'h00, sub}, 8'h07);
    $display("test wake done");
    u_bfm.put_ctrl(8'h01);
    v = 8'($urandom);
    u_bfm.put_data(v);
    u_bfm.get_data(got);
    chk8(got, v & 8'h2f);
    u_bfm.put_ctrl(8'he2);
    for (int k = 0; k < 10; k++) begin
      shadow[k] = 8'($urandom);
      u_bfm.put_data(shadow[k]);
    end
    u_bfm.put_stop;
    u_bfm.put_ctrl(8'he2);
    for (int k = 0; k < 11; k++) begin
      u_bfm.get_data(got);
      chk8(got, shadow[k % 10]);
    end
    $display("test random_regs done");
    u_bfm.put_ctrl(8'h01);
    u_bfm.put_data(8'h00);
    v = 8'($urandom);
    u_bfm.put_ctrl(8'ha2);
    foreach (shadow[k]) if (k < 5) u_bfm.put_data(k == 0 ? v : 8'hff);
    rnd_st();
    measure(shadow[0:4], "deferred");
    u_bfm.put_stop;
    rnd_st();
    measure('{v, 8'hff, 8'hff, 8'hff, 8'hff}, "on_stop");
    // Watchdog: shortest period, silence sets the flag, a bus access clears it
    u_bfm.put_ctrl(8'h01);
    u_bfm.put_data(8'h04);
    repeat (100) @(negedge clk_in);
    chk8({7'h00, wdt}, 8'h01);
    u_bfm.get_data(got);
    chk8({7'h00, wdt}, 8'h00);
    $display("test watchdog done");
    u_bfm.put_ctrl(8'h01);
    u_bfm.put_data(8'h08);
    rnd_st();
    u_bfm.put_ctrl(8'h06);
    u_bfm.put_data(8'h40);
    measure('{v, 8'hff, 8'hff, 8'hff, 8'h40}, "on_ack");
    end_of_test();
  end
endmodule
`default_nettype wire

// [test/lpd_bus_master.sv]
// Partner: byte-level bus master that feeds the core's strobes
`timescale 1ns/1ps
`default_nettype none
module lpd_bus_master (
  // Clock and read path
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  // Strobes and bytes
  output logic            ctrl_wr_out,
  output logic            data_wr_out,
  output logic            data_rd_out,
  output logic            ack_out,
  output logic            stop_out,
  output logic [7:0]      ctrl_data_out,
  output logic [7:0]      data_out
);
  initial begin
    {ctrl_wr_out, data_wr_out, data_rd_out, ack_out, stop_out} = 5'h00;
    ctrl_data_out = 8'h5a;
    data_out = 8'ha5;
  end
  // Released bytes show the inverse, never the last value
  task automatic put_ctrl(input logic [7:0] b);
    @(negedge clk_in); ctrl_data_out = b; ctrl_wr_out = 1'b1;
    @(negedge clk_in); ctrl_wr_out = 1'b0; ctrl_data_out = ~b;
  endtask
  // Data byte, then its acknowledge
  task automatic put_data(input logic [7:0] b);
    @(negedge clk_in); data_out = b; data_wr_out = 1'b1;
    @(negedge clk_in); data_wr_out = 1'b0; data_out = ~b; ack_out = 1'b1;
    @(negedge clk_in); ack_out = 1'b0;
  endtask
  // Byte is taken before the read strobe moves the pointer
  task automatic get_data(output logic [7:0] b);
    @(negedge clk_in); b = rd_data_in; data_rd_out = 1'b1;
    @(negedge clk_in); data_rd_out = 1'b0;
  endtask
  task automatic put_stop;
    @(negedge clk_in); stop_out = 1'b1;
    @(negedge clk_in); stop_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/lpd_core_assertions.sv]
// Checker: port-level properties of the LED dimmer core
`timescale 1ns/1ps
`default_nettype none
module lpd_core_assertions
  import lpd_pkg::*;
(
  // Clock, reset and watched inputs
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        ctrl_wr_in,
  input wire logic [7:0]  ctrl_data_in,
  input wire logic        data_rd_in,
  input wire logic [15:0] led_state_in,
  // Watched outputs
  input wire logic [7:0]  rd_data_out,
  input wire logic [4:0]  reg_ptr_out,
  input wire logic [2:0]  subcall_en_out,
  input wire logic        broadcast_address_enable_out,
  input wire logic        osc_running_out,
  input wire logic [7:0]  led_on_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Reset check must not be masked by the reset itself
  a_reset_values: assert property (disable iff (1'b0) sys_rst_in |=>
    rd_data_out == 8'h11 && reg_ptr_out == 5'h00 && subcall_en_out == 3'h0 &&
    broadcast_address_enable_out && !osc_running_out && led_on_out == 8'h00)
    else $error("reset values wrong");
  // LEDs dark one cycle after the oscillator is down
  a_asleep_dark: assert property (!$past(osc_running_out) |-> led_on_out == 8'h00)
    else $error("LED driven while asleep");
  a_state_off: assert property ($past(led_state_in[1:0]) == ST_OFF |-> !led_on_out[0])
    else $error("LED0 on in off state");
  a_state_on: assert property ($past(osc_running_out) &&
    $past(led_state_in[1:0]) == ST_ON |-> led_on_out[0])
    else $error("LED0 off in on state");
  a_ctrl_ptr: assert property (ctrl_wr_in |=> reg_ptr_out == $past(ctrl_data_in[4:0]))
    else $error("pointer not loaded");
  a_mode_map: assert property (reg_ptr_out == 5'h00 |-> subcall_en_out == rd_data_out[3:1]
    && broadcast_address_enable_out == rd_data_out[0])
    else $error("address enables disagree");
  a_sec_reserved: assert property (reg_ptr_out == 5'h01 |->
    rd_data_out[7:6] == 2'h0 && !rd_data_out[4])
    else $error("reserved bits set");
  // Full-map auto-increment wraps past the last register
  a_wrap_all: assert property (ctrl_wr_in && ctrl_data_in == 8'h91 ##2 data_rd_in
    |=> reg_ptr_out == 5'h00)
    else $error("pointer did not wrap");
endmodule
bind lpd_core lpd_core_assertions u_chk (.clk_in, .sys_rst_in, .ctrl_wr_in, .ctrl_data_in,
  .data_rd_in, .led_state_in, .rd_data_out, .reg_ptr_out, .subcall_en_out,
  .broadcast_address_enable_out, .osc_running_out, .led_on_out);
`default_nettype wire
